/* File: rtl/bsa_bus_outputs.sv */
// upper address, status, latch strobe and byte enable outputs
// What this block does
// - drive address 16-19 in address phase
// - upper address pins zero in data phase
// - address-19 pin in reset requests test mode
// - three status lines encode cycle type
// - strobe address latch each address phase
// - upper byte enable on upper half transfers, refresh flag on narrow bus
// - enable and bit zero encode transfer size
// - upper pins float hold, weak reset, keep
// - status floats hold/reset, high powerdown
// - latch strobe low in hold/reset/powerdown
`timescale 1ns/1ps
module bsa_bus_outputs (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic narrow_bus,
    input wire logic req_valid,
    input wire bsa_pkg::bsa_req_t req,
    input wire logic data_done,
    input wire logic bus_hold,
    input wire logic powerdown,
    input wire logic strap_in,
    output logic req_ready,
    output bsa_pkg::bsa_pins_t pins,
    output logic upper_weak_pull,
    output logic address_bit_zero,
    output logic onchip_emulation_test_mode
);
    bsa_pkg::bsa_phase_t ph_r, ph_nxt;
    bsa_pkg::bsa_req_t cur_r, cur_nxt;
    bsa_pkg::bsa_pins_t pins_r, pins_nxt;
    logic ready_r, ready_nxt;
    logic weak_r, weak_nxt;
    logic a0_r, a0_nxt;
    logic onchip_emulation_test_mode_r, onchip_emulation_test_mode_nxt;
    logic strap_s1_r, strap_s2_r;

    // upper byte enable, active low, from size and low address bit
    function automatic logic ube_n(input bsa_pkg::bsa_req_t r);
        if (r.refresh)
            return 1'b1;
        return ~(r.word | r.addr[0]);
    endfunction

    // strap synchroniser, pin is asynchronous
    always_ff @(posedge clk)
    begin
        strap_s1_r <= strap_in;
        strap_s2_r <= strap_s1_r;
    end

    // next state of the bus phase sequencer and pins
    always_comb
    begin
        ph_nxt = ph_r;
        cur_nxt = cur_r;
        pins_nxt = pins_r;
        ready_nxt = 1'b0;
        weak_nxt = 1'b0;
        a0_nxt = a0_r;
        onchip_emulation_test_mode_nxt = onchip_emulation_test_mode_r;
        pins_nxt.ale = 1'b0;
        pins_nxt.upper_oe_n = 4'h0;
        pins_nxt.status_oe_n = 1'b0;
        pins_nxt.ube_oe_n = 1'b0;
        if (bus_hold)
        begin
            pins_nxt.upper_oe_n = 4'hf;
            pins_nxt.ube_oe_n = 1'b1;
            pins_nxt.status_oe_n = 1'b1;
            pins_nxt.ale = 1'b0;
        end
        else if (powerdown)
        begin
            pins_nxt.bus_cycle_status = bsa_pkg::BSA_ST_PASSIVE;
        end
        else
        begin
            case (ph_r)
                bsa_pkg::BSA_PH_IDLE:
                begin
                    pins_nxt.bus_cycle_status = bsa_pkg::BSA_ST_PASSIVE;
                    if (req_valid)
                    begin
                        cur_nxt = req;
                        ready_nxt = 1'b1;
                        ph_nxt = bsa_pkg::BSA_PH_ADDR;
                        pins_nxt.upper_address_bits =
                            req.addr[bsa_pkg::BSA_UPPER_HI:bsa_pkg::BSA_UPPER_LO];
                        pins_nxt.middle_address_bits =
                            req.addr[bsa_pkg::BSA_MID_HI:bsa_pkg::BSA_MID_LO];
                        pins_nxt.bus_cycle_status = req.kind;
                        pins_nxt.ale = 1'b1;
                        pins_nxt.upper_byte_enable_n = narrow_bus ? ~req.refresh : ube_n(req);
                        a0_nxt = req.refresh ? 1'b1 : req.addr[0];
                    end
                end
                bsa_pkg::BSA_PH_ADDR:
                begin
                    // upper pins to zero in data phase
                    if (!narrow_bus)
                        pins_nxt.upper_address_bits = 4'h0;
                    else
                        pins_nxt.upper_address_bits = 4'h0;
                    ph_nxt = bsa_pkg::BSA_PH_DATA;
                end
                bsa_pkg::BSA_PH_DATA:
                begin
                    if (data_done)
                    begin
                        pins_nxt.bus_cycle_status = bsa_pkg::BSA_ST_PASSIVE;
                        ph_nxt = bsa_pkg::BSA_PH_LAST;
                    end
                end
                bsa_pkg::BSA_PH_LAST:
                begin
                    ph_nxt = bsa_pkg::BSA_PH_IDLE;
                end
                default:
                begin
                    ph_nxt = bsa_pkg::BSA_PH_IDLE;
                end
            endcase
        end
    end

    // registers, reset puts pins in their reset state
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ph_r <= bsa_pkg::BSA_PH_IDLE;
            cur_r <= '0;
            // upper pins weakly high, enable floats
            pins_r.upper_address_bits <= bsa_pkg::BSA_UPPER_RESET;
            pins_r.upper_oe_n <= 4'hf;
            pins_r.middle_address_bits <= bsa_pkg::BSA_MID_RESET;
            pins_r.bus_cycle_status <= bsa_pkg::BSA_ST_PASSIVE;
            pins_r.status_oe_n <= 1'b1;
            pins_r.ale <= 1'b0;
            pins_r.upper_byte_enable_n <= 1'b1;
            pins_r.ube_oe_n <= 1'b1;
            ready_r <= 1'b0;
            weak_r <= 1'b1;
            a0_r <= 1'b0;
            onchip_emulation_test_mode_r <= ~strap_s2_r;
        end
        else
        begin
            ph_r <= ph_nxt;
            cur_r <= cur_nxt;
            pins_r <= pins_nxt;
            ready_r <= ready_nxt;
            weak_r <= weak_nxt;
            a0_r <= a0_nxt;
            onchip_emulation_test_mode_r <= onchip_emulation_test_mode_nxt;
        end
    end

    assign pins = pins_r;
    assign req_ready = ready_r;
    assign upper_weak_pull = weak_r;
    assign address_bit_zero = a0_r;
    assign onchip_emulation_test_mode = onchip_emulation_test_mode_r;

    chk_ale_addr_phase: assert property (@(posedge clk) disable iff (!rst_n)
        pins_r.ale |-> ph_r == bsa_pkg::BSA_PH_ADDR)
        else $error("latch strobe outside address phase");
    // upper bits zero after address phase
    chk_upper_zero_data: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(ph_r == bsa_pkg::BSA_PH_ADDR) && !bus_hold && !powerdown
        |=> pins_r.upper_address_bits == 4'h0)
        else $error("upper address not zero in data phase");
    // no strobe in hold or powerdown
    chk_ale_low_hold: assert property (@(posedge clk) disable iff (!rst_n)
        $past(bus_hold) || $past(powerdown) |-> !pins_r.ale)
        else $error("latch strobe high in hold or powerdown");
    chk_status_hold: assert property (@(posedge clk) disable iff (!rst_n)
        bus_hold |=> pins_r.status_oe_n)
        else $error("status driven during hold");
    chk_upper_hold: assert property (@(posedge clk) disable iff (!rst_n)
        bus_hold |=> pins_r.upper_oe_n == 4'hf && pins_r.ube_oe_n)
        else $error("upper pins driven during hold");
    chk_idle_passive: assert property (@(posedge clk) disable iff (!rst_n)
        ph_r == bsa_pkg::BSA_PH_LAST
        |-> pins_r.bus_cycle_status == bsa_pkg::BSA_ST_PASSIVE)
        else $error("status not passive at cycle end");
    chk_upper_addr: assert property (@(posedge clk) disable iff (!rst_n)
        pins_r.ale |-> pins_r.upper_address_bits == cur_r.addr[19:16])
        else $error("upper address wrong in address phase");
    chk_status_kind: assert property (@(posedge clk) disable iff (!rst_n)
        pins_r.ale |-> pins_r.bus_cycle_status == cur_r.kind)
        else $error("status code does not match cycle");
    chk_mid_stable: assert property (@(posedge clk) disable iff (!rst_n)
        ph_r == bsa_pkg::BSA_PH_DATA && !bus_hold |=> $stable(pins_r.middle_address_bits))
        else $error("middle address changed mid cycle");
endmodule // bsa_bus_outputs

/* File: rtl/bsa_pkg.sv */
// package for the bus status and upper address output block
package bsa_pkg;
    // bus cycle status codes, three lines, bit2 first
    typedef enum logic [2:0] {
        BSA_ST_INTA = 3'h0,
        BSA_ST_IORD = 3'h1,
        BSA_ST_IOWR = 3'h2,
        BSA_ST_HALT = 3'h3,
        BSA_ST_FETCH = 3'h4,
        BSA_ST_MEMRD = 3'h5,
        BSA_ST_MEMWR = 3'h6,
        BSA_ST_PASSIVE = 3'h7
    } bsa_status_t;

    // bus phase sequencer states
    typedef enum logic [1:0] {
        BSA_PH_IDLE = 2'h0,
        BSA_PH_ADDR = 2'h1,
        BSA_PH_DATA = 2'h2,
        BSA_PH_LAST = 2'h3
    } bsa_phase_t;

    // address bit positions
    localparam int BSA_UPPER_LO = 16;
    localparam int BSA_UPPER_HI = 19;
    localparam int BSA_MID_LO = 8;
    localparam int BSA_MID_HI = 15;
    localparam logic [3:0] BSA_UPPER_RESET = 4'hf;
    localparam logic [7:0] BSA_MID_RESET = 8'hff;

    // bus cycle request from the core
    typedef struct packed {
        logic [19:0] addr;
        bsa_status_t kind;
        logic word;
        logic refresh;
    } bsa_req_t;

    // pin group: output values and active-low output enables
    typedef struct packed {
        logic [3:0] upper_address_bits;
        logic [3:0] upper_oe_n;
        logic [7:0] middle_address_bits;
        logic [2:0] bus_cycle_status;
        logic status_oe_n;
        logic ale;
        logic upper_byte_enable_n;
        logic ube_oe_n;
    } bsa_pins_t;
endpackage

/* File: verification/bsa_far_side.sv */
// far side model: external address latch and strap on the top address pin
`timescale 1ns/1ps
module bsa_far_side (
    input wire logic rst_n,
    input wire logic want_test,
    input wire bsa_pkg::bsa_pins_t pins,
    input wire logic upper_weak_pull,
    output logic strap_level,
    output logic [3:0] latched_upper
);
    // transparent latch open while strobe high
    always_latch
    begin
        if (pins.ale)
            latched_upper <= pins.upper_address_bits;
    end
    // strap low only in reset, bits 16-18 never pulled
    always_comb
    begin
        if (!rst_n && want_test)
            strap_level = 1'b0;
        else if (!pins.upper_oe_n[3])
            strap_level = pins.upper_address_bits[3];
        else
            strap_level = upper_weak_pull | ~pins.upper_address_bits[3]; // float reads high under weak pull, else the inverse of the last driven bit 19
    end
endmodule // bsa_far_side

/* File: verification/bsa_bus_outputs_bench.sv */
// testbench for the bus status and upper address output block
`timescale 1ns/1ps
module bsa_bus_outputs_bench;
    logic clk, rst_n, narrow_bus, req_valid, data_done, bus_hold, powerdown, want_test;
    logic req_ready, upper_weak_pull, address_bit_zero, onchip_emulation_test_mode, strap_level;
    logic [3:0] latched_upper;
    bsa_pkg::bsa_req_t req;
    bsa_pkg::bsa_pins_t pins;
    int miscompares, n_tests, cycles;
    bsa_bus_outputs DUT (.clk(clk), .rst_n(rst_n), .narrow_bus(narrow_bus),
        .req_valid(req_valid), .req(req), .data_done(data_done), .bus_hold(bus_hold),
        .powerdown(powerdown), .strap_in(strap_level), .req_ready(req_ready), .pins(pins),
        .upper_weak_pull(upper_weak_pull), .address_bit_zero(address_bit_zero),
        .onchip_emulation_test_mode(onchip_emulation_test_mode));
    bsa_far_side far (.rst_n(rst_n), .want_test(want_test), .pins(pins),
        .upper_weak_pull(upper_weak_pull), .strap_level(strap_level),
        .latched_upper(latched_upper));
    // compare and count
    task automatic cmp(input string what, input logic [19:0] exp, input logic [19:0] got);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // reset with strap choice, pin states in and after reset
    task automatic reset_run(input logic test);
        @(posedge clk);
        want_test <= test;
        rst_n <= 1'b0;
        repeat (7) @(posedge clk);
        #1;
        cmp("upper oe", 20'hf, 20'(pins.upper_oe_n));
        cmp("upper reset", 20'hf, 20'(pins.upper_address_bits));
        cmp("pull", 20'h1, 20'(upper_weak_pull));
        cmp("ube oe", 20'h1, 20'(pins.ube_oe_n));
        cmp("status oe", 20'h1, 20'(pins.status_oe_n));
        cmp("ale", 20'h0, 20'(pins.ale));
        cmp("test mode", 20'(test), 20'(onchip_emulation_test_mode));
        @(posedge clk);
        rst_n <= 1'b1;
        want_test <= 1'b0;
        @(posedge clk);
        #1;
        cmp("pull off", 20'h0, 20'(upper_weak_pull));
        $display("test reset done");
    endtask
    // one full bus cycle, checked phase by phase
    task automatic run_cycle(input logic [19:0] a, input int k, input logic w, input logic f);
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{a, bsa_pkg::bsa_status_t'(k), w, f};
        @(posedge clk);
        req_valid <= 1'b0;
        #1;
        cmp("ready", 20'h1, 20'(req_ready));
        cmp("ale", 20'h1, 20'(pins.ale));
        cmp("upper", 20'(a[19:16]), 20'(pins.upper_address_bits));
        cmp("upper oe", 20'h0, 20'(pins.upper_oe_n));
        cmp("status", 20'(k), 20'(pins.bus_cycle_status));
        cmp("a0", 20'(f | a[0]), 20'(address_bit_zero));
        if (narrow_bus)
            cmp("refresh", 20'(!f), 20'(pins.upper_byte_enable_n));
        else
            cmp("ube", 20'(f | !(w | a[0])), 20'(pins.upper_byte_enable_n));
        @(posedge clk);
        data_done <= 1'b1;
        #1;
        cmp("upper data", 20'h0, 20'(pins.upper_address_bits));
        cmp("ale off", 20'h0, 20'(pins.ale));
        cmp("latch", 20'(a[19:16]), 20'(latched_upper));
        cmp("status hold", 20'(k), 20'(pins.bus_cycle_status));
        if (narrow_bus)
            cmp("middle", 20'(a[15:8]), 20'(pins.middle_address_bits));
        @(posedge clk);
        data_done <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        cmp("passive", 20'h7, 20'(pins.bus_cycle_status));
        $display("test cycle %0d done", k);
    endtask
    // hold or powerdown: pin states and refused requests
    task automatic hold_run(input logic pd);
        @(posedge clk);
        bus_hold <= !pd;
        powerdown <= pd;
        req_valid <= 1'b1;
        repeat (3)
        begin
            @(posedge clk);
            #1;
            cmp("refused", 20'h0, 20'(req_ready));
            cmp("ale", 20'h0, 20'(pins.ale));
        end
        cmp("upper oe", pd ? 20'h0 : 20'hf, 20'(pins.upper_oe_n));
        cmp("ube oe", 20'(!pd), 20'(pins.ube_oe_n));
        cmp("upper keep", 20'h0, 20'(pins.upper_address_bits));
        cmp("status oe", 20'(!pd), 20'(pins.status_oe_n));
        if (pd)
            cmp("status pd", 20'h7, 20'(pins.bus_cycle_status));
        @(posedge clk);
        bus_hold <= 1'b0;
        powerdown <= 1'b0;
        req_valid <= 1'b0;
        $display("test hold %0d done", pd);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // cut a hang short
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            miscompares++;
            finish_test();
        end
    end
    initial
    begin
        {rst_n, narrow_bus, req_valid, data_done, bus_hold, powerdown, want_test} = '0;
        req = '0;
        reset_run(1'b1);
        for (int k = 0; k < 7; k++)
            run_cycle({4'(k + 9), 8'(k * 37), 8'(k * 2)}, k, k[0], 1'b0);
        run_cycle(20'h5a3c7, 5, 1'b0, 1'b0);
        run_cycle(20'h80000, 5, 1'b0, 1'b1);
        hold_run(1'b0);
        hold_run(1'b1);
        narrow_bus <= 1'b1;
        run_cycle(20'hc3a50, 4, 1'b0, 1'b0);
        run_cycle(20'h2f0e1, 5, 1'b0, 1'b1);
        reset_run(1'b0);
        finish_test();
    end
endmodule // bsa_bus_outputs_bench
